// *** core/pin_sync.sv ***
/*
 Two-stage synchroniser for a group of pin inputs.
 Assumes the pins are asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Pins in, synchronised levels out
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second stage
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         stage1 <= '0;
         syncOut <= '0;
      end
      else
      begin
         stage1 <= pinIn;
         syncOut <= stage1;
      end
   end
endmodule
`default_nettype wire

// *** core/sar_adc_pkg.sv ***
/*
 Constants, state type and register map of the converter sequencing,
 power control and serial readout block.
 Assumes a 10 MHz system clock; all cycle counts but WAKE_CYCLES derive from it.
*/
// Function
// R01: Start tracking the next input 527 ns after a conversion starts.
// R02: Give a 1.460 us acquisition interval within each conversion cycle.
// R03: Time conversions internally, never longer than 1.5 us.
// R04: Nap after each conversion; power up on the conversion start rising edge.
// R05: In nap only the core sleeps; serial readout keeps working.
// R06: Two start pulses with no shift clock rise between request sleep.
// R07: Enter sleep when busy falls after a sleep request.
// R08: A shift clock rising edge wakes the device from sleep.
// R09: Host waits the wake settling time before the next conversion.
// R10: Data changes on shift clock rise; host samples on next edge.
// R11: result_msb stays on the data output until the first clock rise.
// R12: Host runs the shift clock fast enough for full throughput.
// R13: Normal mode: output off while read enable high, driven while low.
// R14: Normal mode: new result_msb appears when busy falls.
// R15: Normal mode: read enable falling puts the result MSB out at once.
// R16: Host enables only one shared-output device at a time.
// R17: Chain mode: output always driven; read enable pin is serial input.
// R18: Chain mode: upstream MSB appears downstream after 18 clock cycles.
// R19: Chain mode: serial input captured on clock rises, MSB first.
// R20: Start rising edge begins conversion; busy high while converting.
// R21: Restart attempts during a conversion are ignored.
// R22: Host moves start only early in or after a conversion.
// R23: Host waits 200 us after power-on before converting.
// R24: Result shifts out 18 bits MSB first, one bit per clock rise.
package sar_adc_pkg;
   // Timing base
   localparam int CLK_PERIOD_NS = 100;
   localparam int ACQ_DELAY_NS = 527;
   localparam int ACQ_TIME_NS = 1460;
   localparam int CONV_MAX_NS = 1500;
   localparam int REINIT_US = 200;
   // Least times round up, longest times round down
   localparam int ACQ_DELAY_CYCLES =
      (ACQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACQ_TIME_CYCLES =
      (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_CYCLES = CONV_MAX_NS / CLK_PERIOD_NS;
   localparam int REINIT_CYCLES =
      (REINIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESULT_BITS = 18;
   localparam int WAKE_CYCLES = 1000;
   // Register map, byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_RESULT = 8'h08;
   // Control fields
   localparam int CTRL_SLEEP_EN = 0;
   localparam int CTRL_CONV_EN = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   // Status fields
   localparam int ST_BUSY = 0;
   localparam int ST_NAPPING = 1;
   localparam int ST_ASLEEP = 2;
   localparam int ST_WAKE_DONE = 3;
   localparam int ST_REINIT_DONE = 4;
   localparam int ST_CHAIN = 5;
   localparam int ST_SDO_ON = 6;
   localparam int ST_ACQ_DONE = 7;
   // Sequencer states
   typedef enum logic [1:0] {NAP, CONVERT, SLEEP} conv_state_e;
endpackage

// *** core/sar_adc_readout.sv ***
/*
 Conversion sequencer, nap and sleep control, serial readout and APB
 register slave of an 18-bit successive-approximation converter.
 Assumes the host drives the start, shift clock and read enable pins
 asynchronously, and the analog core returns its code on coreResult
 by the end of each conversion.
*/
`timescale 1ns/1ps
`default_nettype none
module sar_adc_readout #(
   parameter int WAKE_CYCLES = sar_adc_pkg::WAKE_CYCLES,
   parameter int RESULT_BITS = sar_adc_pkg::RESULT_BITS
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Host-facing pins
   input wire logic convStartPin,
   input wire logic sckPin,
   input wire logic readEnChainPin,
   input wire logic daisyModePin,
   output logic busy,
   output logic sdoOut,
   output logic sdoOe,
   // Analog core
   input wire logic [RESULT_BITS-1:0] coreResult,
   output logic corePowered,
   output logic sampleTrack,
   output logic deviceAwake
);
   localparam int CW = 5;
   localparam logic [CW-1:0] CONV_LAST = CW'(sar_adc_pkg::CONV_CYCLES - 1);
   localparam logic [CW-1:0] ACQ_LAST = CW'(sar_adc_pkg::ACQ_DELAY_CYCLES - 1);
   localparam logic [CW-1:0] ACQ_FULL = CW'(sar_adc_pkg::ACQ_TIME_CYCLES);
   localparam logic [11:0] REINIT_LAST = 12'(sar_adc_pkg::REINIT_CYCLES - 1);
   localparam logic [15:0] WAKE_LOAD = 16'(WAKE_CYCLES);

   // Parameter checks
   if (RESULT_BITS < 2 || RESULT_BITS > 32)
      $error("RESULT_BITS out of range");
   if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535)
      $error("WAKE_CYCLES out of range");
   if (sar_adc_pkg::CONV_CYCLES <= sar_adc_pkg::ACQ_DELAY_CYCLES)
      $error("Conversion shorter than acquisition delay");

   sar_adc_pkg::conv_state_e state;
   logic [3:0] pinLevel;
   logic convS, sckS, rdlS, chainMode;
   logic convPrev, sckPrev, rdlPrev;
   logic convRise, sckRise, rdlFall, convEnd, sleepReq;
   logic [CW-1:0] convCount, acqCount, busyRun;
   logic [1:0] pulseCount;
   logic [15:0] wakeCount;
   logic [11:0] reinitCount;
   logic reinitDone;
   logic [1:0] ctrl;
   logic [RESULT_BITS-1:0] shiftReg;
   logic [RESULT_BITS-1:0] resultReg;
   logic apbAccess, apbCommit;

   // Decode of the mapped register addresses
   function automatic logic isMapped(input logic [7:0] addr);
      return addr == sar_adc_pkg::ADDR_CTRL ||
         addr == sar_adc_pkg::ADDR_STATUS ||
         addr == sar_adc_pkg::ADDR_RESULT;
   endfunction

   // Pin synchronisers
   pin_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .pinIn({daisyModePin, readEnChainPin, sckPin, convStartPin}),
      .syncOut(pinLevel)
   );
   assign convS = pinLevel[0];
   assign sckS = pinLevel[1];
   assign rdlS = pinLevel[2];
   assign chainMode = pinLevel[3];

   // Edge detection on synchronised levels
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         convPrev <= 1'b0;
         sckPrev <= 1'b0;
         rdlPrev <= 1'b0; // Synchroniser output resets low, no false fall
      end
      else
      begin
         convPrev <= convS;
         sckPrev <= sckS;
         rdlPrev <= rdlS;
      end
   end
   assign convRise = convS && !convPrev;
   assign sckRise = sckS && !sckPrev;
   assign rdlFall = !rdlS && rdlPrev;
   assign convEnd = state == sar_adc_pkg::CONVERT && convCount == CONV_LAST;
   assign sleepReq = pulseCount == 2'h2 && ctrl[sar_adc_pkg::CTRL_SLEEP_EN];

   // Conversion sequencer with nap, sleep and power outputs
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         state <= sar_adc_pkg::NAP;
         convCount <= '0;
         busy <= 1'b0;
         corePowered <= 1'b0;
         sampleTrack <= 1'b1;
         deviceAwake <= 1'b1;
      end
      else
      begin
         unique case (state)
            sar_adc_pkg::NAP:
            begin
               if (convRise && ctrl[sar_adc_pkg::CTRL_CONV_EN])
               begin
                  state <= sar_adc_pkg::CONVERT; // see R20
                  convCount <= '0;
                  busy <= 1'b1; // see R20
                  corePowered <= 1'b1; // see R04
                  sampleTrack <= 1'b0;
               end
            end
            sar_adc_pkg::CONVERT:
            begin
               // Further start edges are not looked at here, see R21
               convCount <= convCount + 1'b1; // see R03
               if (convCount == ACQ_LAST)
                  sampleTrack <= 1'b1; // see R01
               if (convEnd)
               begin
                  busy <= 1'b0; // see R03
                  corePowered <= 1'b0; // see R04
                  if (sleepReq)
                  begin
                     state <= sar_adc_pkg::SLEEP; // see R07
                     deviceAwake <= 1'b0;
                     sampleTrack <= 1'b0;
                  end
                  else
                     state <= sar_adc_pkg::NAP; // see R05
               end
            end
            sar_adc_pkg::SLEEP:
            begin
               if (sckRise)
               begin
                  state <= sar_adc_pkg::NAP; // see R08
                  deviceAwake <= 1'b1;
                  sampleTrack <= 1'b1;
               end
            end
         endcase
      end
   end

   // Start pulses since the last shift clock rise; the pulse wins
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         pulseCount <= '0;
      else if (convEnd && sleepReq)
         pulseCount <= '0;
      else if (sckRise)
         pulseCount <= convRise ? 2'h1 : 2'h0; // see R06
      else if (convRise && pulseCount != 2'h2)
         pulseCount <= pulseCount + 1'b1; // see R06
   end
   // Acquisition time since tracking began, saturating
   always_ff @(posedge clk_sys)
   begin
      if (reset || !sampleTrack)
         acqCount <= '0;
      else if (acqCount != ACQ_FULL)
         acqCount <= acqCount + 1'b1; // see R02
   end
   // Wake settling countdown after leaving sleep
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         wakeCount <= '0;
      else if (state == sar_adc_pkg::SLEEP && sckRise)
         wakeCount <= WAKE_LOAD; // see R09
      else if (wakeCount != 16'h0000)
         wakeCount <= wakeCount - 1'b1;
   end
   // Re-initialisation interval after reset
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         reinitCount <= '0;
         reinitDone <= 1'b0;
      end
      else if (!reinitDone)
      begin
         reinitCount <= reinitCount + 1'b1;
         reinitDone <= reinitCount == REINIT_LAST; // see R23
      end
   end

   // Result capture and serial shift register
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         shiftReg <= '0;
         resultReg <= '0;
      end
      else if (convEnd)
      begin
         shiftReg <= coreResult; // see R14
         resultReg <= coreResult;
      end
      else if (sckRise)
         // MSB first; chain input enters at the bottom, see R18
         shiftReg <= {shiftReg[RESULT_BITS-2:0],
            chainMode && rdlS}; // see R24 see R19 see R10
      else if (!chainMode && rdlFall)
         shiftReg <= resultReg; // see R15
   end
   // Holds the MSB until the first clock rise, see R11
   assign sdoOut = shiftReg[RESULT_BITS-1];
   // Data output enable
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         sdoOe <= 1'b0;
      else
         sdoOe <= chainMode || !rdlS; // see R13 see R17
   end

   // Control register, written at the completing edge
   assign apbAccess = psel && penable && !pready;
   assign apbCommit = psel && penable && pready && pwrite;
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         ctrl <= sar_adc_pkg::CTRL_RESET;
      else if (apbCommit && paddr == sar_adc_pkg::ADDR_CTRL)
         ctrl <= pwdata[1:0];
   end

   // APB answer with one wait state
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else
      begin
         pready <= apbAccess;
         pslverr <= apbAccess && !isMapped(paddr);
         prdata <= '0;
         if (apbAccess && !pwrite)
         begin
            unique case (paddr)
               sar_adc_pkg::ADDR_CTRL: prdata <= {30'h0, ctrl};
               sar_adc_pkg::ADDR_STATUS:
               begin
                  prdata[sar_adc_pkg::ST_BUSY] <= busy;
                  prdata[sar_adc_pkg::ST_NAPPING] <= state == sar_adc_pkg::NAP;
                  prdata[sar_adc_pkg::ST_ASLEEP] <= !deviceAwake;
                  prdata[sar_adc_pkg::ST_WAKE_DONE] <= wakeCount == 16'h0000;
                  prdata[sar_adc_pkg::ST_REINIT_DONE] <= reinitDone;
                  prdata[sar_adc_pkg::ST_CHAIN] <= chainMode;
                  prdata[sar_adc_pkg::ST_SDO_ON] <= sdoOe;
                  prdata[sar_adc_pkg::ST_ACQ_DONE] <= acqCount == ACQ_FULL;
               end
               sar_adc_pkg::ADDR_RESULT: prdata <= 32'(resultReg);
               default: prdata <= '0;
            endcase
         end
      end
   end

   // Checks on the sequencer and readout
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   // Busy cycles so far, a helper for the length check
   always_ff @(posedge clk_sys)
      busyRun <= (reset || !busy) ? '0 : busyRun + 1'b1;
   property p_acqDelay;
      $rose(busy) |-> !sampleTrack [*6] ##1 sampleTrack;
   endproperty
   a_acqDelay: assert property (p_acqDelay) // see R01
      else $error("Tracking did not start at the acquisition delay");
   property p_convTime;
      (busy |-> busyRun <= CONV_LAST) and
         ($fell(busy) |-> busyRun == CONV_LAST + 1'b1);
   endproperty
   a_convTime: assert property (p_convTime) // see R03
      else $error("Conversion length wrong");
   property p_noRestart;
      busy && convRise |=> convCount == $past(convCount) + 1'b1;
   endproperty
   a_noRestart: assert property (p_noRestart) // see R21
      else $error("Conversion restarted while busy");
   property p_napPower;
      $fell(busy) |-> !corePowered && !$past(corePowered, 16);
   endproperty
   a_napPower: assert property (p_napPower) // see R04
      else $error("Core not powered down after conversion");
   property p_napShift;
      sckRise && !busy && !chainMode && !rdlFall |=>
         shiftReg[RESULT_BITS-1:1] == $past(shiftReg[RESULT_BITS-2:0]);
   endproperty
   a_napShift: assert property (p_napShift) // see R05
      else $error("Readout did not shift during nap");
   property p_sleepEntry;
      convEnd && sleepReq |=> !deviceAwake && !busy;
   endproperty
   a_sleepEntry: assert property (p_sleepEntry) // see R07
      else $error("Sleep not entered at end of conversion");
   property p_wake;
      !deviceAwake && sckRise |=> deviceAwake && wakeCount == WAKE_LOAD;
   endproperty
   a_wake: assert property (p_wake) // see R08
      else $error("Shift clock rise did not wake device");
   property p_outputOff;
      !chainMode && rdlS |=> !sdoOe;
   endproperty
   a_outputOff: assert property (p_outputOff) // see R13
      else $error("Output driven while read enable high");
   property p_chainDrive;
      chainMode |=> sdoOe;
   endproperty
   a_chainDrive: assert property (p_chainDrive) // see R17
      else $error("Output not driven in chain mode");
   property p_msbOnEnd;
      convEnd |=> !busy && sdoOut == $past(coreResult[RESULT_BITS-1]);
   endproperty
   a_msbOnEnd: assert property (p_msbOnEnd) // see R14
      else $error("New MSB missing when busy fell");
   property p_readEnable;
      rdlFall && !chainMode && !sckRise && !convEnd |=>
         sdoOut == resultReg[RESULT_BITS-1];
   endproperty
   a_readEnable: assert property (p_readEnable) // see R15
      else $error("MSB not presented on read enable");
   property p_chainCapture;
      sckRise && chainMode && !convEnd |=> shiftReg[0] == $past(rdlS);
   endproperty
   a_chainCapture: assert property (p_chainCapture) // see R19
      else $error("Chain input not captured");
endmodule
`default_nettype wire

// *** verif/host_model.sv ***
/*
 Host model on the converter pins: start pulses, shift clock,
 read enable and chain input. Assumes clk_sys paces every change.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Clock
   input wire logic clk_sys,
   // Device output
   input wire logic sdoOut,
   // Pins to device
   output logic convStart,
   output logic sck,
   output logic readEn,
   output logic chainMode
);
   // Idle levels, shift clock still
   initial
   begin
      convStart = 1'b0;
      sck = 1'b0;
      readEn = 1'b1;
      chainMode = 1'b0;
   end
   // Start pulse, low again before the conversion runs
   task automatic pulse();
      convStart <= 1'b1;
      repeat (2) @(posedge clk_sys);
      convStart <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
   // Mode and read enable levels
   task automatic set(input logic re, input logic ch);
      readEn <= re;
      chainMode <= ch;
      repeat (4) @(posedge clk_sys);
   endtask
   // One 800 ns clock period; bit sampled before the rise
   task automatic tick(input logic d, output logic q);
      sck <= 1'b0;
      if (chainMode)
         readEn <= d;
      repeat (4) @(posedge clk_sys);
      q = sdoOut;
      sck <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask
   // Whole frame, MSB first; clock left low
   task automatic frame(input logic [17:0] din, output logic [17:0] dout);
      logic q;
      for (int i = 17; i >= 0; i--)
      begin
         tick(din[i], q);
         dout[i] = q;
      end
      sck <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
   // A single rise, as used to wake the device
   task automatic wake();
      logic q;
      tick(1'b1, q);
      sck <= 1'b0;
   endtask
endmodule
`default_nettype wire

// *** verif/sar_adc_readout_bench.sv ***
/*
 Bench for the converter readout block: host model on the pins,
 APB master on the registers, random codes from the analog core.
 Assumes clk_sys at 10 MHz and a shortened wake settling count.
*/
`timescale 1ns/1ps
`default_nettype none
module sar_adc_readout_bench;
   localparam int WK = 40;
   // Clock, reset and APB
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr;
   // Pins and analog core
   logic cs, sck, re, ch, busy, sdoOut, sdoOe;
   logic corePowered, sampleTrack, deviceAwake;
   logic [17:0] coreResult = 18'h00000;
   // Bookkeeping
   int errors = 0;
   int checked = 0;
   int nBusy, nHold, nPow;
   logic [31:0] seed = 32'h487A;
   logic [31:0] rd;
   logic err;
   logic [17:0] r, u, q;

   always #50 clk_sys = ~clk_sys;

   // Count busy cycles, cycles before tracking and powered cycles
   always @(posedge clk_sys)
   begin
      if (busy === 1'b1)
      begin
         nBusy <= nBusy + 1;
         nHold <= nHold + int'(sampleTrack === 1'b0);
         nPow <= nPow + int'(corePowered === 1'b1);
      end
   end

   sar_adc_readout #(.WAKE_CYCLES(WK)) u_dut (.clk_sys(clk_sys),
      .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .convStartPin(cs), .sckPin(sck),
      .readEnChainPin(re), .daisyModePin(ch), .busy(busy),
      .sdoOut(sdoOut), .sdoOe(sdoOe), .coreResult(coreResult),
      .corePowered(corePowered), .sampleTrack(sampleTrack),
      .deviceAwake(deviceAwake));

   host_model u_host (.clk_sys(clk_sys), .sdoOut(sdoOut),
      .convStart(cs), .sck(sck), .readEn(re), .chainMode(ch));

   // Expectations from the stated times at a 100 ns clock
   function automatic int convCycles();
      return 1500 / 100;
   endfunction
   function automatic int holdCycles();
      return (527 + 99) / 100;
   endfunction
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic results();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic hang();
      errors++;
      $display("[FAIL] %0t wait ran out", $time);
      results();
   endtask
   task automatic cmp(input logic [31:0] g, e, input string m);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %0t %s got %h", $time, m, g);
      end
   endtask
   // APB transfer; read data and error land in rd and err
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
      if (n >= 20)
         hang();
   endtask
   task automatic waitBusy(input logic v);
      int n;
      n = 0;
      while (busy !== v && n < 100)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (busy !== v)
         hang();
   endtask
   // One conversion of code v, optionally a second start while busy
   task automatic conv(input logic [17:0] v, input logic again);
      nBusy = 0;
      nHold = 0;
      nPow = 0;
      coreResult <= v;
      u_host.pulse();
      waitBusy(1'b1);
      if (again)
         u_host.pulse();
      waitBusy(1'b0);
      cmp(nBusy, convCycles(), "busy length");
      cmp(nHold, holdCycles(), "hold length");
      cmp(nPow, convCycles(), "core power");
      cmp(sdoOut, v[17], "msb at busy fall");
      cmp(corePowered, 1'b0, "nap");
   endtask

   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (2000) @(posedge clk_sys);
      apb(1'b0, sar_adc_pkg::ADDR_STATUS, 32'h0);
      cmp(rd[sar_adc_pkg::ST_REINIT_DONE], 1'b1, "reinit");
      apb(1'b0, sar_adc_pkg::ADDR_CTRL, 32'h0);
      cmp(rd, {30'h0, sar_adc_pkg::CTRL_RESET}, "ctrl reset");
      apb(1'b1, 8'h0C, 32'hFFFFFFFF);
      cmp(err, 1'b1, "unmapped write");
      apb(1'b0, 8'h0C, 32'h0);
      cmp({rd[30:0], err}, 32'h1, "unmapped read");
      $display("test registers done");
      u_host.set(1'b0, 1'b0);
      for (int i = 0; i < 6; i++)
      begin
         rd = rnd();
         r = i == 0 ? 18'h20000 : i == 1 ? 18'h1FFFF : rd[17:0];
         conv(r, 1'b0);
         cmp(sdoOe, 1'b1, "sdo on");
         u_host.frame(18'h0, q);
         cmp(q, r, "frame");
      end
      apb(1'b0, sar_adc_pkg::ADDR_STATUS, 32'h0);
      cmp(rd[sar_adc_pkg::ST_ACQ_DONE], 1'b1, "acquisition");
      conv(r, 1'b0);
      u_host.tick(1'b0, q[0]);
      u_host.tick(1'b0, q[0]);
      u_host.set(1'b1, 1'b0);
      cmp(sdoOe, 1'b0, "sdo off");
      u_host.set(1'b0, 1'b0);
      cmp({sdoOe, sdoOut}, {1'b1, r[17]}, "reload msb");
      u_host.frame(18'h0, q);
      cmp(q, r, "reload frame");
      $display("test normal done");
      apb(1'b1, sar_adc_pkg::ADDR_CTRL, 32'h2);
      conv(r, 1'b1);
      repeat (8) @(posedge clk_sys);
      cmp(busy, 1'b0, "no restart");
      cmp(deviceAwake, 1'b1, "sleep disabled");
      u_host.frame(18'h0, q);
      cmp(q, r, "restart frame");
      apb(1'b1, sar_adc_pkg::ADDR_CTRL, 32'h3);
      $display("test restart done");
      u_host.set(1'b1, 1'b1);
      cmp(sdoOe, 1'b1, "chain drive");
      rd = rnd();
      u = rd[17:0];
      rd = rnd();
      r = rd[17:0];
      conv(r, 1'b0);
      u_host.frame(u, q);
      cmp(q, r, "own word");
      u_host.frame(18'h0, q);
      cmp(q, u, "upstream word");
      u_host.set(1'b0, 1'b0);
      $display("test chain done");
      conv(r, 1'b0);
      conv(r, 1'b0);
      @(posedge clk_sys);
      cmp(deviceAwake, 1'b0, "asleep");
      u_host.pulse();
      repeat (8) @(posedge clk_sys);
      cmp(busy, 1'b0, "start while asleep");
      u_host.wake();
      cmp(deviceAwake, 1'b1, "woken");
      apb(1'b0, sar_adc_pkg::ADDR_STATUS, 32'h0);
      cmp(rd[sar_adc_pkg::ST_WAKE_DONE], 1'b0, "settling");
      repeat (WK) @(posedge clk_sys);
      apb(1'b0, sar_adc_pkg::ADDR_STATUS, 32'h0);
      cmp(rd[sar_adc_pkg::ST_WAKE_DONE], 1'b1, "settled");
      conv(r, 1'b0);
      u_host.frame(18'h0, q);
      cmp(q, r, "after wake");
      $display("test sleep done");
      results();
   end
endmodule
`default_nettype wire
